// ---- rtl/vpaa_regs.sv ----
`timescale 1ns/1ps
// Function
// (RQ1) loader rewrites advertisement after reset and reload
// (RQ2) upper half reserved zero, 16-bit management view
// (RQ3) next page bit reads zero, read-only
// (RQ4) remote fault zero; bits 14, 12 reserved
// (RQ5) bit 11 asymmetric pause, writable, resets zero
// (RQ6) bit 10 pause defaults to inverted strap
// (RQ7) strap captured at reset release
// (RQ8) 100BASE-T4 bit reads zero, read-only
// (RQ9) bits 8, 7 100BASE-X abilities, reset one
// (RQ10) bits 6, 5 10BASE-T abilities, reset one
// (RQ11) selector writable, resets to 802.3 code
// (RQ12) partner register read-only, emulated internally
// (RQ13) partner next page zero, acknowledge one
// (RQ14) writes to read-only bits are ignored
module vpaa_regs
  import vpaa_pkg::*;
(
  // clock and reset
  input  wire logic        clk_in,
  input  wire logic        sys_rst_in,
  // configuration strap pin
  input  wire logic        pause_default_strap_in,
  // host register map, 32-bit words
  input  wire logic [11:0] host_addr_in,
  input  wire logic        host_wr_in,
  input  wire logic        host_rd_in,
  input  wire logic [31:0] host_wdata_in,
  output logic      [31:0] host_rdata_out,
  output logic             host_rvalid_out,
  // management access, 16-bit registers
  input  wire logic [4:0]  mii_reg_in,
  input  wire logic        mii_wr_in,
  input  wire logic        mii_rd_in,
  input  wire logic [15:0] mii_wdata_in,
  output logic      [15:0] mii_rdata_out,
  output logic             mii_rvalid_out,
  // configuration loader
  input  wire logic        reload_in,
  input  wire logic        load_wr_in,
  input  wire logic [15:0] load_data_in,
  output logic             load_req_out
);
  vpaa_strap_if strap ();   // captured strap
  logic [15:0] adv_r;       // advertisement register
  logic [15:0] adv_nxt;
  logic [15:0] lp_val;      // emulated partner word
  logic        pend_r;      // loader rewrite pending
  logic        pend_nxt;
  logic        seen_r;      // strap capture already applied
  logic        seen_nxt;
  logic [31:0] hrd_r;       // host read data
  logic [31:0] hrd_nxt;
  logic        hrv_r;       // host read valid
  logic [15:0] mrd_r;       // management read data
  logic [15:0] mrd_nxt;
  logic        mrv_r;       // management read valid
  logic        host_adv_wr; // host write hits advertisement
  logic        mii_adv_wr;  // management write hits advertisement

  // strap synchroniser and capture
  vpaa_strap_capture u_strap (
    .clk_in       (clk_in),
    .sys_rst_in   (sys_rst_in),
    .strap_pin_in (pause_default_strap_in),
    .strap        (strap.src)
  );

  // merge a write into writable bits only
  function automatic logic [15:0] merge_wr(input logic [15:0] cur,
                                           input logic [15:0] wd);
    merge_wr = (cur & ~VPAA_ADV_WMASK) | (wd & VPAA_ADV_WMASK); // RQ14
  endfunction

  // partner word tracks own abilities, fixed top bits
  always_comb begin
    lp_val = (adv_r & VPAA_LP_MIRROR) | VPAA_LP_FIXED; // RQ12 RQ13
  end

  assign host_adv_wr = host_wr_in && (host_addr_in == VPAA_OFF_ADV);
  assign mii_adv_wr  = mii_wr_in && (mii_reg_in == VPAA_IDX_ADV);

  // advertisement next value: strap capture, then loader, then host, then management
  always_comb begin
    adv_nxt  = adv_r;
    seen_nxt = seen_r;
    if (strap.strap_valid && !seen_r) begin
      adv_nxt[VPAA_BIT_PAUSE] = !strap.strap_level; // RQ6 RQ7
      seen_nxt = 1'b1;
    end else if (load_wr_in) begin
      adv_nxt = merge_wr(adv_r, load_data_in);      // RQ1 RQ14
    end else if (host_adv_wr) begin
      adv_nxt = merge_wr(adv_r, host_wdata_in[15:0]); // RQ5 RQ9 RQ10
    end else if (mii_adv_wr) begin
      adv_nxt = merge_wr(adv_r, mii_wdata_in);      // RQ11 RQ2
    end
  end

  // loader request: set after strap capture or reload
  always_comb begin
    pend_nxt = pend_r;
    if (load_wr_in) begin
      pend_nxt = 1'b0;
    end
    if ((strap.strap_valid && !seen_r) || reload_in) begin
      pend_nxt = 1'b1; // RQ1
    end
  end

  // read mux, host words zero-padded above bit 15
  always_comb begin
    hrd_nxt = 32'h0000_0000;   // unmapped reads as zero
    mrd_nxt = 16'h0000;
    if (host_rd_in) begin
      if (host_addr_in == VPAA_OFF_ADV) begin
        hrd_nxt = {16'h0000, adv_r}; // RQ2
      end else if (host_addr_in == VPAA_OFF_LP) begin
        hrd_nxt = {16'h0000, lp_val}; // RQ2 RQ12
      end
    end
    if (mii_rd_in) begin
      if (mii_reg_in == VPAA_IDX_ADV) begin
        mrd_nxt = adv_r; // RQ2
      end else if (mii_reg_in == VPAA_IDX_LP) begin
        mrd_nxt = lp_val;
      end
    end
  end

  // registers
  always_ff @(posedge clk_in or posedge sys_rst_in) begin
    if (sys_rst_in) begin
      adv_r  <= VPAA_ADV_RST; // RQ3 RQ4 RQ5 RQ8 RQ9 RQ10 RQ11
      pend_r <= 1'b0;
      seen_r <= 1'b0;
      hrd_r  <= 32'h0000_0000;
      hrv_r  <= 1'b0;
      mrd_r  <= 16'h0000;
      mrv_r  <= 1'b0;
    end else begin
      adv_r  <= adv_nxt;
      pend_r <= pend_nxt;
      seen_r <= seen_nxt;
      hrd_r  <= hrd_nxt;
      hrv_r  <= host_rd_in;
      mrd_r  <= mrd_nxt;
      mrv_r  <= mii_rd_in;
    end
  end

  assign host_rdata_out  = hrd_r;
  assign host_rvalid_out = hrv_r;
  assign mii_rdata_out   = mrd_r;
  assign mii_rvalid_out  = mrv_r;
  assign load_req_out    = pend_r;

  // loader write lands in every writable field
  property p_rq1_load;
    @(posedge clk_in) disable iff (sys_rst_in)
      (load_wr_in && seen_r) |=>
        (adv_r == (($past(load_data_in) & VPAA_ADV_WMASK)
                   | ($past(adv_r) & ~VPAA_ADV_WMASK)));
  endproperty
  a_rq1_load: assert property (p_rq1_load) // RQ1
    else $error("loader write not applied");

  // reload raises the loader request next cycle
  property p_rq1_req;
    @(posedge clk_in) disable iff (sys_rst_in)
      reload_in |=> load_req_out;
  endproperty
  a_rq1_req: assert property (p_rq1_req) // RQ1
    else $error("reload did not request loader");

  // host words carry zero in the upper half
  property p_rq2_pad;
    @(posedge clk_in) disable iff (sys_rst_in)
      host_rvalid_out |-> (host_rdata_out[31:16] == 16'h0000);
  endproperty
  a_rq2_pad: assert property (p_rq2_pad) // RQ2
    else $error("reserved upper half not zero");

  // next page and T4 read zero on management reads
  property p_rq3_np;
    @(posedge clk_in) disable iff (sys_rst_in)
      (mii_rvalid_out && ($past(mii_reg_in) == VPAA_IDX_ADV)) |->
        !mii_rdata_out[VPAA_BIT_NP] && !mii_rdata_out[VPAA_BIT_T4];
  endproperty
  a_rq3_np: assert property (p_rq3_np) // RQ3
    else $error("next page or T4 reads one");

  // fixed bits survive a host write of all ones
  property p_rq4_ro;
    @(posedge clk_in) disable iff (sys_rst_in)
      (host_adv_wr && !load_wr_in) |=>
        (adv_r[15:12] == 4'h0) && !adv_r[VPAA_BIT_T4];
  endproperty
  a_rq4_ro: assert property (p_rq4_ro) // RQ4
    else $error("read-only bit changed by write");

  // writable speed bits follow a host write
  property p_rq9_wr;
    @(posedge clk_in) disable iff (sys_rst_in)
      (host_adv_wr && !load_wr_in && seen_r) |=>
        (adv_r[8:0] == ($past(host_wdata_in[8:0]) & 9'h1FF
                        & VPAA_ADV_WMASK[8:0]));
  endproperty
  a_rq9_wr: assert property (p_rq9_wr) // RQ9
    else $error("ability bits not written");

  // pause default is the inverted captured strap
  property p_rq6_pause;
    @(posedge clk_in) disable iff (sys_rst_in)
      (strap.strap_valid && !seen_r) |=>
        (adv_r[VPAA_BIT_PAUSE] == !$past(strap.strap_level));
  endproperty
  a_rq6_pause: assert property (p_rq6_pause) // RQ6
    else $error("pause default wrong for strap");

  // partner read: ack one, next page zero, rest mirrored
  property p_rq13_lp;
    @(posedge clk_in) disable iff (sys_rst_in)
      (host_rvalid_out && ($past(host_addr_in) == VPAA_OFF_LP)) |->
        (host_rdata_out[15:14] == 2'b01)
        && (host_rdata_out[13:0] == $past(adv_r[13:0]));
  endproperty
  a_rq13_lp: assert property (p_rq13_lp) // RQ13
    else $error("partner word wrong");

  c_reload: cover property (@(posedge clk_in) disable iff (sys_rst_in)
    reload_in ##[1:20] load_wr_in);
  c_host_wr: cover property (@(posedge clk_in) disable iff (sys_rst_in)
    host_adv_wr ##1 host_rd_in);
  c_strap_hi: cover property (@(posedge clk_in) disable iff (sys_rst_in)
    strap.strap_valid && strap.strap_level);
  c_lp_read: cover property (@(posedge clk_in) disable iff (sys_rst_in)
    mii_rd_in && (mii_reg_in == VPAA_IDX_LP));
endmodule // vpaa_regs

// ---- rtl/vpaa_pkg.sv ----
package vpaa_pkg;
  // host map byte offsets, one 32-bit word each
  localparam logic [11:0] VPAA_OFF_ADV     = 12'h1D0;
  localparam logic [11:0] VPAA_OFF_LP      = 12'h1D4;
  // management register indices, 16-bit view
  localparam logic [4:0]  VPAA_IDX_ADV     = 5'h04;
  localparam logic [4:0]  VPAA_IDX_LP      = 5'h05;
  // field positions in the advertisement and partner registers
  localparam int          VPAA_BIT_NP      = 15;
  localparam int          VPAA_BIT_RF      = 13;
  localparam int          VPAA_BIT_ASYM    = 11;
  localparam int          VPAA_BIT_PAUSE   = 10;
  localparam int          VPAA_BIT_T4      = 9;
  localparam int          VPAA_BIT_ACK     = 14;
  // writable bits: 11, 10, 8..5, 4..0
  localparam logic [15:0] VPAA_ADV_WMASK   = 16'h0DFF;
  // value after reset, pause bit settled later by the strap
  localparam logic [15:0] VPAA_ADV_RST     = 16'h01E1;
  // emulated partner: acknowledge set, next page clear
  localparam logic [15:0] VPAA_LP_FIXED    = 16'h4000;
  localparam logic [15:0] VPAA_LP_MIRROR   = 16'h3FFF;
  // cycles the strap synchroniser fills before capture
  localparam logic [1:0]  VPAA_STRAP_SETTLE = 2'h3;
endpackage

// ---- rtl/vpaa_strap_if.sv ----
`timescale 1ns/1ps
// captured strap level handed to the register bank
interface vpaa_strap_if;
  logic strap_level;   // captured pause default strap
  logic strap_valid;   // high once captured, stays high
  modport src (output strap_level, output strap_valid);
  modport dst (input strap_level, input strap_valid);
endinterface

// ---- rtl/vpaa_strap_capture.sv ----
`timescale 1ns/1ps
// samples the strap pin once after reset release
module vpaa_strap_capture
  import vpaa_pkg::*;
(
  // clock and reset
  input  wire logic   clk_in,
  input  wire logic   sys_rst_in,
  // strap pin
  input  wire logic   strap_pin_in,
  // captured value
  vpaa_strap_if.src   strap
);
  logic [2:0] sync_r;     // three-stage synchroniser
  logic [2:0] sync_nxt;
  logic [1:0] settle_r;   // cycles since reset release
  logic [1:0] settle_nxt;
  logic       level_r;    // captured strap level
  logic       level_nxt;
  logic       valid_r;    // capture done
  logic       valid_nxt;

  // next state: capture once the last two stages agree
  always_comb begin
    sync_nxt   = {sync_r[1:0], strap_pin_in};
    settle_nxt = settle_r;
    level_nxt  = level_r;
    valid_nxt  = valid_r;
    if (settle_r != VPAA_STRAP_SETTLE) begin
      settle_nxt = settle_r + 2'h1;
    end else if (!valid_r && (sync_r[1] == sync_r[2])) begin
      level_nxt = sync_r[2]; // RQ7
      valid_nxt = 1'b1;      // RQ7
    end
  end

  // registers, constants only under reset
  always_ff @(posedge clk_in or posedge sys_rst_in) begin
    if (sys_rst_in) begin
      sync_r   <= 3'h0;
      settle_r <= 2'h0;
      level_r  <= 1'b0;
      valid_r  <= 1'b0;
    end else begin
      sync_r   <= sync_nxt;
      settle_r <= settle_nxt;
      level_r  <= level_nxt;
      valid_r  <= valid_nxt;
    end
  end

  assign strap.strap_level = level_r;
  assign strap.strap_valid = valid_r;

  // captured value comes from agreeing late stages
  property p_rq7_capture;
    @(posedge clk_in) disable iff (sys_rst_in)
      $rose(valid_r) |-> (level_r == $past(sync_r[2]))
                         && ($past(sync_r[1]) == $past(sync_r[2]));
  endproperty
  a_rq7_capture: assert property (p_rq7_capture) // RQ7
    else $error("strap captured without agreement");

  // capture never changes once taken
  property p_rq7_hold;
    @(posedge clk_in) disable iff (sys_rst_in)
      valid_r |=> valid_r && $stable(level_r);
  endproperty
  a_rq7_hold: assert property (p_rq7_hold) // RQ7
    else $error("strap capture changed after release");
endmodule // vpaa_strap_capture

// ---- tb/tb.sv ----
`timescale 1ns/1ps
// register bank bench: strap default, loader, host and mii access
module tb;
  import vpaa_pkg::*;
  // clock, reset, strap
  logic        clk_in;
  logic        sys_rst_in;
  logic        strap;
  // host map side
  logic [11:0] host_addr_in;
  logic        host_wr_in;
  logic        host_rd_in;
  logic [31:0] host_wdata_in;
  logic [31:0] host_rdata_out;
  logic        host_rvalid_out;
  // management side
  logic [4:0]  mii_reg_in;
  logic        mii_wr_in;
  logic        mii_rd_in;
  logic [15:0] mii_wdata_in;
  logic [15:0] mii_rdata_out;
  logic        mii_rvalid_out;
  // loader side
  logic        reload_in;
  logic        load_wr_in;
  logic [15:0] load_data_in;
  logic        load_req_out;
  // bench state
  int          fail_count;
  int          compares;
  int          cycles;
  logic [31:0] seed;
  logic [15:0] adv;      // expected advertisement value
  logic [31:0] rd;

  vpaa_regs u_vpaa_regs (
    .clk_in(clk_in), .sys_rst_in(sys_rst_in),
    .pause_default_strap_in(strap),
    .host_addr_in(host_addr_in), .host_wr_in(host_wr_in),
    .host_rd_in(host_rd_in), .host_wdata_in(host_wdata_in),
    .host_rdata_out(host_rdata_out), .host_rvalid_out(host_rvalid_out),
    .mii_reg_in(mii_reg_in), .mii_wr_in(mii_wr_in),
    .mii_rd_in(mii_rd_in), .mii_wdata_in(mii_wdata_in),
    .mii_rdata_out(mii_rdata_out), .mii_rvalid_out(mii_rvalid_out),
    .reload_in(reload_in), .load_wr_in(load_wr_in),
    .load_data_in(load_data_in), .load_req_out(load_req_out));

  // 50 MHz clock
  initial clk_in = 1'b0;
  always #10 clk_in = ~clk_in;

  // xorshift source, fixed start
  function automatic logic [31:0] rnd();
    seed = seed ^ (seed << 13);
    seed = seed ^ (seed >> 17);
    seed = seed ^ (seed << 5);
    return seed;
  endfunction

  // only writable bits survive a write
  function automatic logic [15:0] wmask(input logic [15:0] d);
    return d & 16'h0DFF;
  endfunction

  // emulated partner: ack set, next page clear, abilities mirrored
  function automatic logic [15:0] lp_of(input logic [15:0] a);
    return {2'b01, a[13:0]};
  endfunction

  // compare and report
  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    compares++;
    if (seen !== exp) begin
      fail_count++;
      $display("Error at %0t: saw %h expected %h", $time, seen, exp);
    end
  endtask

  // verdict and end of run
  task automatic stop_test();
    $display("fail_count=%0d compares=%0d", fail_count, compares);
    if (fail_count == 0 && compares > 0)
      $display("All checks passed");
    else
      $display("Checks failed");
    $finish;
  endtask

  // hang guard
  always @(posedge clk_in) begin
    cycles++;
    if (cycles == 5000) begin
      fail_count++;
      stop_test();
    end
  end

  // host read, rvalid checked just after the taking edge
  task automatic host_rd(input logic [11:0] a, output logic [31:0] d);
    @(posedge clk_in);
    host_addr_in <= a;
    host_rd_in   <= 1'b1;
    @(posedge clk_in);
    host_rd_in   <= 1'b0;
    #1;
    check({31'h0, host_rvalid_out}, 32'h1);
    d = host_rdata_out;
  endtask

  // host or mii write pulse
  task automatic wr(input logic mii, input logic [11:0] a,
                    input logic [15:0] d);
    @(posedge clk_in);
    if (mii) begin
      mii_reg_in   <= a[4:0];
      mii_wdata_in <= d;
      mii_wr_in    <= 1'b1;
    end else begin
      host_addr_in  <= a;
      host_wdata_in <= {rnd() & 32'hFFFF0000} | {16'h0, d};
      host_wr_in    <= 1'b1;
    end
    @(posedge clk_in);
    mii_wr_in  <= 1'b0;
    host_wr_in <= 1'b0;
  endtask

  // mii read of one index
  task automatic mii_rd(input logic [4:0] r, output logic [15:0] d);
    @(posedge clk_in);
    mii_reg_in <= r;
    mii_rd_in  <= 1'b1;
    @(posedge clk_in);
    mii_rd_in  <= 1'b0;
    #1;
    check({31'h0, mii_rvalid_out}, 32'h1);
    d = mii_rdata_out;
  endtask

  // read both views of both registers against the model
  task automatic check_all();
    logic [15:0] m;
    host_rd(12'h1D0, rd);
    check(rd, {16'h0, adv});
    host_rd(12'h1D4, rd);
    check(rd, {16'h0, lp_of(adv)});
    mii_rd(5'h04, m);
    check({16'h0, m}, {16'h0, adv});
    mii_rd(5'h05, m);
    check({16'h0, m}, {16'h0, lp_of(adv)});
  endtask

  // reset with a strap level, then loader request and pause default
  task automatic do_reset(input logic s);
    sys_rst_in <= 1'b1;
    strap      <= s;
    repeat (2) @(posedge clk_in);
    sys_rst_in <= 1'b0;
    repeat (8) @(posedge clk_in);
    #1;
    check({31'h0, load_req_out}, 32'h1);
    adv = s ? 16'h01E1 : 16'h05E1;
    check_all();
  endtask

  // loader write of a whole word
  task automatic load(input logic [15:0] d);
    @(posedge clk_in);
    load_data_in <= d;
    load_wr_in   <= 1'b1;
    @(posedge clk_in);
    load_wr_in   <= 1'b0;
    #1;
    check({31'h0, load_req_out}, 32'h0);
    adv = wmask(d);
  endtask

  // main sequence
  initial begin
    logic [15:0] d;
    logic [15:0] corner [4];
    corner = '{16'hFFFF, 16'h0000, 16'hF200, 16'h0C01};
    fail_count = 0;
    compares = 0;
    cycles = 0;
    seed = 32'h9161;
    sys_rst_in = 1'b1;
    strap = 1'b0;
    host_addr_in = 12'h000;
    host_wr_in = 1'b0;
    host_rd_in = 1'b0;
    host_wdata_in = 32'h0;
    mii_reg_in = 5'h00;
    mii_wr_in = 1'b0;
    mii_rd_in = 1'b0;
    mii_wdata_in = 16'h0;
    reload_in = 1'b0;
    load_wr_in = 1'b0;
    load_data_in = 16'h0;
    do_reset(1'b0);
    // read-only bits set, selector kept at the only legal code
    load(16'hFFE1);
    check_all();
    // corner then random writes, advertisement over mii, partner over host
    for (int i = 0; i < 24; i++) begin
      d = (i < 4) ? corner[i] : 16'(rnd());
      // software may only write the 802.3 selector code
      d[4:0] = 5'h01;
      wr(d[0], d[0] ? 12'h004 : 12'h1D0, d);
      adv = wmask(d);
      wr(d[1], d[1] ? 12'h005 : 12'h1D4, ~d);
      check_all();
    end
    // unmapped place reads zero
    host_rd(12'h1D8, rd);
    check(rd, 32'h0);
    // reload command raises a new loader request
    @(posedge clk_in);
    reload_in <= 1'b1;
    @(posedge clk_in);
    reload_in <= 1'b0;
    #1;
    check({31'h0, load_req_out}, 32'h1);
    load(16'h0421);
    check_all();
    do_reset(1'b1);
    stop_test();
  end
endmodule // tb
